// [verilog/dcsic_dev_end.sv]
// converter end: registers, skew loop, sync, fifo, interpolation, clock ratio
`timescale 1ns/1ns
`default_nettype none
`include "dcsic_map.svh"
module dcsic_dev_end #(
    parameter int         DEPTH        = 8,
    parameter int         LOCK_EDGES   = 16,
    parameter int         PLL_LOCK_CYC = 64,
    parameter logic [2:0] DEV_ID       = 3'h5,   // arbitrary
    parameter logic [1:0] DEV_VER      = 2'h1    // arbitrary
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    dcsic_link_if.dev        lnk,
    output logic [15:0]      dac_code_o,
    output logic             skew_lock_o,
    output logic             conv_lock_o,
    output logic             conv_mult_o,
    output logic signed [3:0] ratio_log2_o,
    output logic [1:0]       div_phase_o
);
    localparam int AW = $clog2(DEPTH);

    logic [7:0] fir_ctl, filt_mode, sync_ctl, clk_ctl, skew_restart;
    logic [7:0] mult_div, skew_loop_config, osc_ctl, serial_out_function_select;
    logic sync_m, sync_s, sync_d, dclk_m, dclk_s, dclk_d;
    logic [15:0] bus_m, bus_s;
    logic [7:0] lock_cnt;
    logic [10:0] idle_cnt;
    logic skew_lock, pll_lock;
    logic [11:0] pll_cnt;
    logic [15:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr;
    logic [1:0] div_cnt;
    logic [15:0] prev, cur, mid_last;

    function automatic logic [15:0] interp(input logic [15:0] a, input logic [15:0] b,
                                           input logic odd, input logic hp);
        logic [16:0] s;
        logic [15:0] v;
        s = {a[15], a} + {b[15], b};
        v = odd ? s[16:1] : b;
        // high-pass flips every other output sample to take the upper image
        interp = (hp && odd) ? 16'(-v) : v;
    endfunction

    function automatic logic [2:0] log_code(input logic [4:0] code, input logic [2:0] top);
        log_code = (code > {2'h0, top}) ? top : code[2:0];
    endfunction

    wire rst     = !rst_n_i || !lnk.chip_reset_low;
    wire wr_fir  = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_FIRCTL;
    wire wr_filt = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_FILT;
    wire wr_sync = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_SYNC;
    wire wr_clk  = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_CLK;
    wire wr_rst  = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_RESTART;
    wire wr_mult = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_MULT;
    wire wr_skew = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_SKEW;
    wire wr_osc  = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_OSC;
    wire wr_sdo  = lnk.cfg_we && lnk.cfg_addr == `DCSIC_A_SDO;

    wire [7:0] status_word_first = {pll_lock, skew_lock, 1'b0, DEV_ID, DEV_VER};
    wire [7:0] rd_mux =
        lnk.cfg_addr == `DCSIC_A_STATUS  ? status_word_first :
        lnk.cfg_addr == `DCSIC_A_FIRCTL  ? fir_ctl :
        lnk.cfg_addr == `DCSIC_A_FILT    ? filt_mode :
        lnk.cfg_addr == `DCSIC_A_SYNC    ? sync_ctl :
        lnk.cfg_addr == `DCSIC_A_CLK     ? clk_ctl :
        lnk.cfg_addr == `DCSIC_A_RESTART ? skew_restart :
        lnk.cfg_addr == `DCSIC_A_MULT    ? mult_div :
        lnk.cfg_addr == `DCSIC_A_SKEW    ? skew_loop_config :
        lnk.cfg_addr == `DCSIC_A_OSC     ? osc_ctl :
        lnk.cfg_addr == `DCSIC_A_SDO     ? serial_out_function_select : 8'h00;

    wire restart      = skew_restart[`DCSIC_B_RESTART];
    wire div_dis      = clk_ctl[`DCSIC_B_DIVDIS];
    wire mult_mode    = !clk_ctl[`DCSIC_B_BYPASS];
    wire halve        = osc_ctl[`DCSIC_B_HALVE];
    wire sync_rise    = sync_s && !sync_d;
    wire sync_toggle  = sync_s ^ sync_d;
    wire dclk_edge    = dclk_s ^ dclk_d;
    wire [7:0] lock_target = 8'(LOCK_EDGES) + {4'h0, skew_loop_config[7:4]};
    wire [10:0] idle_limit = 11'h008 << skew_loop_config[2:0];
    // software bit only when selected; multi-device setups keep select at zero
    wire gate = sync_ctl[`DCSIC_B_SOFT_SEL] ? sync_ctl[`DCSIC_B_SOFT_SYNC] : sync_s;
    wire fir_on = fir_ctl[`DCSIC_B_FIRENA];
    dcsic_pkg::dcsic_mode_t mode;
    assign mode = !fir_on ? dcsic_pkg::DCSIC_X1 :
                  filt_mode[`DCSIC_B_FIR2X4X] ? dcsic_pkg::DCSIC_X4 : dcsic_pkg::DCSIC_X2;
    wire slot = (mode == dcsic_pkg::DCSIC_X1) ||
                (mode == dcsic_pkg::DCSIC_X2 && !div_cnt[0]) || (div_cnt == 2'h0);
    wire fifo_empty = rd_ptr == wr_ptr;
    wire take = gate && slot && !fifo_empty;
    wire [15:0] mid = interp(prev, cur, div_cnt[1], filt_mode[`DCSIC_B_HP0]);
    wire [15:0] next_code =
        mode == dcsic_pkg::DCSIC_X1 ? cur :
        mode == dcsic_pkg::DCSIC_X2 ? interp(prev, cur, div_cnt[0], filt_mode[`DCSIC_B_HP1]) :
        interp(mid_last, mid, div_cnt[0], filt_mode[`DCSIC_B_HP1]);
    wire [2:0] n_log = log_code({2'h0, mult_div[2:0]}, 3'h3);
    wire [2:0] m_log = log_code(mult_div[7:3], 3'h5);
    wire signed [3:0] next_ratio = 4'($signed({1'b0, m_log}) - $signed({1'b0, n_log}) -
                                      $signed({3'h0, halve}));
    wire pll_touch = wr_mult || wr_osc || wr_clk;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            fir_ctl <= `DCSIC_R_FIRCTL;
            filt_mode <= `DCSIC_R_FILT;
            sync_ctl <= `DCSIC_R_SYNC;
            clk_ctl <= `DCSIC_R_ZERO;
            skew_restart <= `DCSIC_R_ZERO;
            mult_div <= `DCSIC_R_ZERO;
            skew_loop_config <= `DCSIC_R_ZERO;
            osc_ctl <= `DCSIC_R_ZERO;
            serial_out_function_select <= `DCSIC_R_ZERO;
        end else begin
            if (wr_fir) fir_ctl <= lnk.cfg_wdata;
            if (wr_filt) filt_mode <= lnk.cfg_wdata;
            if (wr_sync) sync_ctl <= lnk.cfg_wdata;
            if (wr_clk) clk_ctl <= lnk.cfg_wdata;
            if (wr_rst) skew_restart <= lnk.cfg_wdata;
            if (wr_mult) mult_div <= lnk.cfg_wdata;
            if (wr_skew) skew_loop_config <= lnk.cfg_wdata;
            if (wr_osc) osc_ctl <= lnk.cfg_wdata;
            if (wr_sdo) serial_out_function_select <= lnk.cfg_wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            lnk.cfg_rdata <= 8'h00;
            lnk.cfg_rvalid <= 1'b0;
            lnk.serial_out <= 1'b0;
        end else begin
            lnk.cfg_rdata <= lnk.cfg_re ? rd_mux : 8'h00;
            lnk.cfg_rvalid <= lnk.cfg_re;
            lnk.serial_out <= serial_out_function_select[7:5] == `DCSIC_SDO_LOCK && skew_lock;
        end
    end

    // two stages on the sync, data clock and sample bus inputs; data bus shares the clock path delay
    always_ff @(posedge clk_i) begin
        if (rst) begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
            dclk_m <= 1'b0;
            dclk_s <= 1'b0;
            dclk_d <= 1'b0;
            bus_m <= 16'h0000;
            bus_s <= 16'h0000;
        end else begin
            sync_m <= lnk.transmit_sync_input;
            sync_s <= sync_m;
            sync_d <= sync_s;
            dclk_m <= lnk.data_clock_pair;
            dclk_s <= dclk_m;
            dclk_d <= dclk_s;
            bus_m <= lnk.sample_bus;
            bus_s <= bus_m;
        end
    end

    // skew loop: counts data clock edges to lock, drops on a stalled clock
    always_ff @(posedge clk_i) begin
        if (rst || restart) begin
            lock_cnt <= 8'h00;
            idle_cnt <= 11'h000;
            skew_lock <= 1'b0;
        end else if (dclk_edge) begin
            idle_cnt <= 11'h000;
            if (!skew_lock && lock_cnt == lock_target) skew_lock <= 1'b1;
            else if (!skew_lock) lock_cnt <= lock_cnt + 8'h01;
        end else if (idle_cnt == idle_limit) begin
            lock_cnt <= 8'h00;
            skew_lock <= 1'b0;
        end else begin
            idle_cnt <= idle_cnt + 11'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dclk_edge && skew_lock) mem[wr_ptr] <= bus_s;
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            div_cnt <= 2'h0;
        end else begin
            if (dclk_edge && skew_lock) wr_ptr <= wr_ptr + 1'b1;
            if (sync_rise && div_dis) rd_ptr <= wr_ptr - AW'(fir_ctl[2:0]);
            else if (take) rd_ptr <= rd_ptr + 1'b1;
            if (sync_toggle && !div_dis) div_cnt <= 2'h0;
            else div_cnt <= div_cnt + 2'h1;
        end
    end

    // prev and cur step only on divider slots that find a word in the fifo, so latency follows the fifo fill
    always_ff @(posedge clk_i) begin
        if (rst) begin
            prev <= 16'h0000;
            cur <= 16'h0000;
            mid_last <= 16'h0000;
            dac_code_o <= 16'h0000;
        end else begin
            if (take) prev <= cur;
            if (take) cur <= mem[rd_ptr];
            if (div_cnt[0]) mid_last <= mid;
            dac_code_o <= gate ? next_code : 16'h0000;
        end
    end

    // multiplier model: lock after settings stay untouched long enough
    always_ff @(posedge clk_i) begin
        if (rst || pll_touch || !mult_mode) begin
            pll_cnt <= 12'h000;
            pll_lock <= 1'b0;
        end else if (pll_cnt == 12'(PLL_LOCK_CYC)) begin
            pll_lock <= 1'b1;
        end else begin
            pll_cnt <= pll_cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            skew_lock_o <= 1'b0;
            conv_lock_o <= 1'b0;
            conv_mult_o <= 1'b0;
            ratio_log2_o <= 4'sh0;
            div_phase_o <= 2'h0;
        end else begin
            skew_lock_o <= skew_lock;
            conv_lock_o <= mult_mode ? pll_lock : 1'b1;
            conv_mult_o <= mult_mode;
            ratio_log2_o <= mult_mode ? next_ratio : 4'sh0;
            div_phase_o <= div_cnt;
        end
    end
endmodule // dcsic_dev_end
`default_nettype wire

// [verilog/dcsic_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef DCSIC_MAP_SVH
`define DCSIC_MAP_SVH
`define DCSIC_A_STATUS   5'h00
`define DCSIC_A_FIRCTL   5'h01
`define DCSIC_A_FILT     5'h02
`define DCSIC_A_SYNC     5'h03
`define DCSIC_A_CLK      5'h05
`define DCSIC_A_RESTART  5'h08
`define DCSIC_A_MULT     5'h09
`define DCSIC_A_SKEW     5'h0a
`define DCSIC_A_OSC      5'h0b
`define DCSIC_A_SDO      5'h0e
`define DCSIC_B_CONVLOCK 7
`define DCSIC_B_SKEWLOCK 6
`define DCSIC_B_FIRENA   4
`define DCSIC_B_FIR2X4X  5
`define DCSIC_B_HP1      2
`define DCSIC_B_HP0      0
`define DCSIC_B_SOFT_SYNC 1
`define DCSIC_B_SOFT_SEL  0
`define DCSIC_B_DIVDIS   5
`define DCSIC_B_BYPASS   1
`define DCSIC_B_RESTART  3
`define DCSIC_B_HALVE    6
`define DCSIC_R_FIRCTL   8'h10
`define DCSIC_R_FILT     8'hc0
`define DCSIC_R_SYNC     8'h70
`define DCSIC_R_ZERO     8'h00
`define DCSIC_SDO_LOCK   3'h1
`define DCSIC_CLK_NS     4
`define DCSIC_RST_NS     25
`define DCSIC_RST_CYC    ((`DCSIC_RST_NS + `DCSIC_CLK_NS - 1) / `DCSIC_CLK_NS)
`define DCSIC_ALIGN_CYC  50
`define DCSIC_REF_MAX    160
`define DCSIC_HALVE_MHZ  500
`endif

// [verilog/dcsic_pkg.sv]
// shared types of the converter clock and sync control
package dcsic_pkg;
    typedef enum logic [1:0] {DCSIC_X1, DCSIC_X2, DCSIC_X4} dcsic_mode_t;
    typedef enum logic [2:0] {H_RESET, H_CFG, H_RELEASE, H_POLL, H_PWAIT, H_DIVSYNC, H_WAIT, H_TX} dcsic_hst_t;
endpackage

// [verilog/dcsic_link_if.sv]
// link between sample source and converter control
`timescale 1ns/1ns
`default_nettype none
interface dcsic_link_if;
    logic        chip_reset_low;
    logic        transmit_sync_input;
    logic        data_clock_pair;
    logic [15:0] sample_bus;
    logic        cfg_we;
    logic        cfg_re;
    logic [4:0]  cfg_addr;
    logic [7:0]  cfg_wdata;
    logic [7:0]  cfg_rdata;
    logic        cfg_rvalid;
    logic        serial_out;
    modport dev (input chip_reset_low, transmit_sync_input, data_clock_pair, sample_bus,
                 cfg_we, cfg_re, cfg_addr, cfg_wdata, output cfg_rdata, cfg_rvalid, serial_out);
    modport host (output chip_reset_low, transmit_sync_input, data_clock_pair, sample_bus,
                  cfg_we, cfg_re, cfg_addr, cfg_wdata, input cfg_rdata, cfg_rvalid, serial_out);
endinterface // dcsic_link_if
`default_nettype wire

// [verilog/dcsic_host_end.sv]
// source end: reset, configuration, lock poll, sync steps, sample stream
`timescale 1ns/1ns
`default_nettype none
`include "dcsic_map.svh"
module dcsic_host_end #(
    parameter int SPACE      = 4,
    parameter int REF_MHZ    = 100,
    parameter int TARGET_MHZ = 1000,
    parameter int SETTLE     = 64,
    parameter int SYNC_PULSE = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    dcsic_link_if.host       lnk,
    input  wire logic        start_i,
    input  wire dcsic_pkg::dcsic_mode_t mode_i,
    input  wire logic        hp0_i,
    input  wire logic        hp1_i,
    input  wire logic        use_pll_i,
    input  wire logic [4:0]  m_code_i,
    input  wire logic [2:0]  n_code_i,
    input  wire logic [7:0]  skew_cfg_i,
    input  wire logic [2:0]  fifo_offset_i,
    input  wire logic [15:0] sample_i,
    input  wire logic        sample_valid_i,
    output logic             sample_ready_o,
    output logic             running_o
);
    dcsic_pkg::dcsic_hst_t st;
    logic [3:0] step;
    logic [7:0] cnt;
    logic [7:0] space_cnt;

    wire halve = use_pll_i && TARGET_MHZ < `DCSIC_HALVE_MHZ;
    wire [2:0] n_use = (REF_MHZ > `DCSIC_REF_MAX && n_code_i == 3'h0) ? 3'h1 : n_code_i;
    wire [4:0] m_use = halve ? m_code_i + 5'h01 : m_code_i;
    wire fir_on = mode_i != dcsic_pkg::DCSIC_X1;
    wire x4 = mode_i == dcsic_pkg::DCSIC_X4;

    function automatic logic [12:0] cfg_word(input logic [3:0] k);
        unique case (k)
            4'h0: cfg_word = {`DCSIC_A_FIRCTL, 3'h0, fir_on, 1'b0, fifo_offset_i};
            4'h1: cfg_word = {`DCSIC_A_FILT, 2'h0, x4, 2'h0, hp1_i, 1'b0, hp0_i};
            4'h2: cfg_word = {`DCSIC_A_SYNC, 8'h00};
            4'h3: cfg_word = {`DCSIC_A_CLK, 6'h00, !use_pll_i, 1'b0};
            4'h4: cfg_word = {`DCSIC_A_MULT, m_use, n_use};
            4'h5: cfg_word = {`DCSIC_A_SKEW, skew_cfg_i};
            4'h6: cfg_word = {`DCSIC_A_OSC, 1'b0, halve, 6'h00};
            default: cfg_word = {`DCSIC_A_RESTART, 8'h08};
        endcase
    endfunction

    wire [12:0] word = cfg_word(step);
    wire slot = space_cnt == 8'(SPACE - 1);
    wire clock_on = st != dcsic_pkg::H_RESET && st != dcsic_pkg::H_CFG;
    wire take = sample_ready_o && sample_valid_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= dcsic_pkg::H_RESET;
            step <= 4'h0;
            cnt <= 8'h00;
            lnk.chip_reset_low <= 1'b0;
            lnk.transmit_sync_input <= 1'b0;
            lnk.cfg_we <= 1'b0;
            lnk.cfg_re <= 1'b0;
            lnk.cfg_addr <= 5'h00;
            lnk.cfg_wdata <= 8'h00;
            running_o <= 1'b0;
        end else begin
            lnk.cfg_we <= 1'b0;
            lnk.cfg_re <= 1'b0;
            cnt <= cnt + 8'h01;
            unique case (st)
                dcsic_pkg::H_RESET: begin
                    lnk.chip_reset_low <= !(cnt < 8'(`DCSIC_RST_CYC));
                    if (start_i && lnk.chip_reset_low) begin
                        st <= dcsic_pkg::H_CFG;
                        step <= 4'h0;
                    end
                end
                dcsic_pkg::H_CFG: begin
                    lnk.cfg_we <= 1'b1;
                    lnk.cfg_addr <= word[12:8];
                    lnk.cfg_wdata <= word[7:0];
                    step <= step + 4'h1;
                    cnt <= 8'h00;
                    if (step == 4'h7) st <= dcsic_pkg::H_RELEASE;
                end
                dcsic_pkg::H_RELEASE: begin
                    if (cnt == 8'(SETTLE)) begin
                        lnk.cfg_we <= 1'b1;
                        lnk.cfg_addr <= `DCSIC_A_RESTART;
                        lnk.cfg_wdata <= 8'h00;
                        st <= dcsic_pkg::H_POLL;
                    end
                end
                dcsic_pkg::H_POLL: begin
                    lnk.cfg_re <= 1'b1;
                    lnk.cfg_addr <= `DCSIC_A_STATUS;
                    st <= dcsic_pkg::H_PWAIT;
                end
                dcsic_pkg::H_PWAIT: begin
                    cnt <= 8'h00;
                    if (lnk.cfg_rvalid && lnk.cfg_rdata[`DCSIC_B_SKEWLOCK]) st <= dcsic_pkg::H_DIVSYNC;
                    else if (lnk.cfg_rvalid) st <= dcsic_pkg::H_POLL;
                end
                dcsic_pkg::H_DIVSYNC: begin
                    lnk.transmit_sync_input <= cnt < 8'(SYNC_PULSE);
                    if (cnt == 8'(SYNC_PULSE)) begin
                        lnk.cfg_we <= 1'b1;
                        lnk.cfg_addr <= `DCSIC_A_CLK;
                        lnk.cfg_wdata <= {2'h0, 1'b1, 3'h0, !use_pll_i, 1'b0};
                        cnt <= 8'h00;
                        st <= dcsic_pkg::H_WAIT;
                    end
                end
                dcsic_pkg::H_WAIT: begin
                    // pointer sync only in the cycle before a slot so the first word rides the sync edge
                    if (cnt >= 8'(`DCSIC_ALIGN_CYC) && space_cnt == 8'(SPACE - 2)) begin
                        lnk.transmit_sync_input <= 1'b1;
                        running_o <= 1'b1;
                        st <= dcsic_pkg::H_TX;
                    end
                end
                dcsic_pkg::H_TX: begin
                    lnk.transmit_sync_input <= 1'b1;
                end
            endcase
        end
    end

    // data clock toggles once per word, words on both edges
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            space_cnt <= 8'h00;
            lnk.data_clock_pair <= 1'b0;
            lnk.sample_bus <= 16'h0000;
            sample_ready_o <= 1'b0;
        end else begin
            space_cnt <= slot ? 8'h00 : space_cnt + 8'h01;
            sample_ready_o <= (st == dcsic_pkg::H_TX || running_o) && space_cnt == 8'(SPACE - 2);
            if (slot && clock_on) begin
                lnk.data_clock_pair <= !lnk.data_clock_pair;
                lnk.sample_bus <= take ? sample_i : 16'h0000;
            end
        end
    end
endmodule // dcsic_host_end
`default_nettype wire

// [test/dcsic_link_asserts.sv]
// assertions on the link between the source end and the converter end
`timescale 1ns/1ns
`default_nettype none
module dcsic_link_asserts (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        chip_reset_low,
    input wire logic        transmit_sync_input,
    input wire logic        data_clock_pair,
    input wire logic [15:0] sample_bus,
    input wire logic        cfg_we,
    input wire logic        cfg_re,
    input wire logic [4:0]  cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        cfg_rvalid,
    input wire logic        serial_out
);
    logic [5:0] low_cnt;
    logic [5:0] fall_cnt;
    logic       lock_seen;
    logic       restart_seen;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // reset time itself counts as low time, hence the start at one
    always_ff @(posedge clk_i) begin
        low_cnt      <= !rst_n_i ? 6'h01 : chip_reset_low ? 6'h00 : low_cnt + {5'h00, ~&low_cnt};
        fall_cnt     <= !rst_n_i ? 6'h3f : $fell(transmit_sync_input) ? 6'h01 : fall_cnt + {5'h00, ~&fall_cnt};
        lock_seen    <= chip_reset_low && (lock_seen || (cfg_rvalid && cfg_rdata[6]));
        restart_seen <= chip_reset_low && (restart_seen || (cfg_we && cfg_addr == 5'h08 && cfg_wdata[3]));
    end
    property p_read_answer; cfg_re |=> cfg_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");
    property p_idle_zero; !cfg_rvalid |-> cfg_rdata == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data without answer");
    property p_dclk_space; $changed(data_clock_pair) |=> $stable(data_clock_pair); endproperty
    a_dclk_space: assert property (p_dclk_space) else $error("data clock toggles too close");
    property p_bus_with_clock; $changed(sample_bus) |-> $changed(data_clock_pair); endproperty
    a_bus_with_clock: assert property (p_bus_with_clock) else $error("word moved off clock edge");
    property p_reset_width; $rose(chip_reset_low) |-> low_cnt >= 6'h07; endproperty
    a_reset_width: assert property (p_reset_width) else $error("chip reset pulse too short");
    property p_sync_after_lock; $rose(transmit_sync_input) |-> lock_seen; endproperty
    a_sync_after_lock: assert property (p_sync_after_lock) else $error("sync before lock read");
    property p_pointer_wait; $rose(transmit_sync_input) |-> fall_cnt >= 6'h32; endproperty
    a_pointer_wait: assert property (p_pointer_wait) else $error("pointer sync too early");
    property p_restart_order; cfg_we && cfg_addr == 5'h08 && !cfg_wdata[3] |-> restart_seen; endproperty
    a_restart_order: assert property (p_restart_order) else $error("restart cleared unset");
    c_lock_read: cover property (cfg_rvalid && cfg_rdata[6]);
    c_sync_rise: cover property ($rose(transmit_sync_input));
    c_word_sent: cover property ($changed(data_clock_pair) && sample_bus != 16'h0000);
endmodule // dcsic_link_asserts
`default_nettype wire

// [test/tb.sv]
// testbench: both ends joined, start-up runs across modes and clock ratios
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  start = 1'b0;
    dcsic_pkg::dcsic_mode_t mode = dcsic_pkg::DCSIC_X1;
    logic                  hp1 = 1'b0;
    logic                  hp0 = 1'b0;
    logic                  sample_valid = 1'b0;
    logic                  use_pll = 1'b0;
    logic [4:0]            m_code = 5'h00;
    logic [2:0]            n_code = 3'h0;
    logic [15:0]           sample = 16'h0000;
    logic                  sample_ready;
    logic                  running;
    logic [15:0]           dac_code;
    logic                  skew_lock;
    logic                  conv_lock;
    logic                  conv_mult;
    logic signed [3:0]     ratio_log2;
    int                    failures = 0;
    int                    check_count = 0;
    int                    cycles = 0;
    dcsic_link_if lnk ();
    dcsic_host_end #(.SETTLE(8)) dcsic_host_end_i (.clk_i(clk), .rst_n_i(rst_n), .lnk(lnk.host),
        .start_i(start), .mode_i(mode), .hp0_i(hp0), .hp1_i(hp1), .use_pll_i(use_pll), .m_code_i(m_code),
        .n_code_i(n_code), .skew_cfg_i(8'h13), .fifo_offset_i(3'h2), .sample_i(sample),
        .sample_valid_i(sample_valid), .sample_ready_o(sample_ready), .running_o(running));
    dcsic_dev_end #(.LOCK_EDGES(4), .PLL_LOCK_CYC(8)) dcsic_dev_end_i (.clk_i(clk), .rst_n_i(rst_n),
        .lnk(lnk.dev), .dac_code_o(dac_code), .skew_lock_o(skew_lock), .conv_lock_o(conv_lock),
        .conv_mult_o(conv_mult), .ratio_log2_o(ratio_log2), .div_phase_o());
    dcsic_link_asserts dcsic_link_asserts_i (.clk_i(clk), .rst_n_i(rst_n),
        .chip_reset_low(lnk.chip_reset_low), .transmit_sync_input(lnk.transmit_sync_input),
        .data_clock_pair(lnk.data_clock_pair), .sample_bus(lnk.sample_bus), .cfg_we(lnk.cfg_we),
        .cfg_re(lnk.cfg_re), .cfg_addr(lnk.cfg_addr), .cfg_wdata(lnk.cfg_wdata),
        .cfg_rdata(lnk.cfg_rdata), .cfg_rvalid(lnk.cfg_rvalid), .serial_out(lnk.serial_out));
    always #2 clk = ~clk;
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // each run resets both ends, so a second reset in mid-run is exercised too
    task automatic run_cfg(input dcsic_pkg::dcsic_mode_t md, input logic h1, input logic pll,
                           input logic [4:0] m, input logic [2:0] n, input logic [15:0] s, input logic h0);
        logic       seen_neg;
        logic [3:0] exp_ratio;
        seen_neg = 1'b0;
        exp_ratio = pll ? 4'((m > 5'h05 ? 5'h05 : m) - {2'h0, (n > 3'h3 ? 3'h3 : n)}) : 4'h0;
        @(negedge clk);
        rst_n = 1'b0;
        start = 1'b0;
        mode = md;
        hp1 = h1;
        hp0 = h0;
        sample_valid = 1'b0;
        use_pll = pll;
        m_code = m;
        n_code = n;
        sample = s;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        start = 1'b1;
        for (int i = 0; i < 2000 && !running; i++) begin
            @(negedge clk);
            `TB_CHK("gated code", 16'h0000, dac_code)
        end
        `TB_CHK("running", 1'b1, running)
        // data clock runs from release before any ready slot, so zero words lead the stream
        sample_valid = 1'b1;
        // constant words let the settled filter output be predicted exactly
        repeat (80) begin
            @(negedge clk);
            seen_neg |= (dac_code === -s);
        end
        `TB_CHK("skew lock", 1'b1, skew_lock)
        `TB_CHK("conv lock", 1'b1, conv_lock)
        `TB_CHK("multiplier mode", pll, conv_mult)
        `TB_CHK("ratio", exp_ratio, ratio_log2)
        if (h1 || h0) `TB_CHK("high pass image", 1'b1, seen_neg)
        else `TB_CHK("passed code", s, dac_code)
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        run_cfg(dcsic_pkg::DCSIC_X1, 1'b0, 1'b0, 5'h00, 3'h0, 16'h1234, 1'b0);
        run_cfg(dcsic_pkg::DCSIC_X2, 1'b0, 1'b1, 5'h03, 3'h1, 16'h2345, 1'b0);
        run_cfg(dcsic_pkg::DCSIC_X2, 1'b1, 1'b1, 5'h07, 3'h0, 16'h0456, 1'b0);
        run_cfg(dcsic_pkg::DCSIC_X4, 1'b0, 1'b1, 5'h02, 3'h7, 16'h0567, 1'b0);
        run_cfg(dcsic_pkg::DCSIC_X4, 1'b0, 1'b0, 5'h00, 3'h0, 16'h0678, 1'b1);
        final_report();
    end
endmodule // tb
`default_nettype wire
